/* rtl/ptp_clock_control.sv */
// ptp real-time clock control registers, time holding words and rate words
//
// Contract
// - With the follow-disable bit (15) set, timers, shapers and policers ignore clock adjustments, otherwise they follow them;
//   the code gates only the rate adjust on o_freq_adj_en and signals no step or load.
// - Writing one to the step bit (6) adds or subtracts the staged nanosecond value once, then the bit clears.
// - The step-direction bit (5) chooses add when one and subtract when zero.
// - Writing one to the snapshot bit (4) copies the live time into the holding words 0x0502-0x050b, then the bit clears.
// - Writing one to the load bit (3) overwrites the running time from the holding words, then the bit clears.
// - While the continuous-adjust bit (2) is set the rate value is added or subtracted on every tick.
// - The run bit (1) lets the clock count when one and halts it when zero.
// - Writing one to the clock-reset bit (0) returns the time to zero, then the bit clears.
// - The 3-bit phase field names the 8 ns slot of the 40 ns tick, codes 0 to 4.
// - Phase codes 5 to 7 are never loaded by software nor reported by the device.
// - The nanosecond high holding word carries nanosecond bits 31:16 for snapshot, load and step.
// - The nanosecond low holding word at 0x0506 carries nanosecond bits 15:0.
// - The seconds count is held as a high word at 0x0508 and a low word at 0x050a.
// - The rate-direction bit (15 of rate high) adds the rate when one and subtracts when zero.
// - The 30-bit rate has bits 29:16 in rate high bits 13:0 and bits 15:0 in rate low.
`timescale 1ns/1ps
module ptp_clock_control
    import ptp_clock_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_rtc_tick,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    output logic             o_reg_rvalid,
    output logic             o_freq_adj_en,
    output logic             o_freq_adj_dir,
    output logic             o_rtc_running
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic        follow_dis;
        logic        step_dir;
        logic        cont_en;
        logic        run;
        logic        step_p;
        logic        snap_p;
        logic        load_p;
        logic        clr_p;
        logic [2:0]  hold_phase;
        logic [15:0] hold_ns_hi;
        logic [15:0] hold_ns_lo;
        logic [15:0] hold_sec_hi;
        logic [15:0] hold_sec_lo;
        logic        rate_dir;
        logic        temp_mode;
        logic [13:0] rate_hi;
        logic [15:0] rate_lo;
        logic [15:0] rdata;
        logic        rvalid;
        logic        adj_en;
        logic        adj_dir;
    } regs_s;

    regs_s st;
    regs_s next_st;

    rtc_ctl_if ctl_if ();

    ////////////////////////////////////////////////////////////////////////////////
    // time counter

    rtc_time_counter u_counter (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .ctl       (ctl_if.cnt)
    );

    assign ctl_if.tick     = i_rtc_tick;
    assign ctl_if.run      = st.run;
    assign ctl_if.clr      = st.clr_p;
    assign ctl_if.load     = st.load_p;
    assign ctl_if.step     = st.step_p;
    assign ctl_if.step_dir = st.step_dir;
    assign ctl_if.cont_en  = st.cont_en;
    assign ctl_if.rate_dir = st.rate_dir;
    assign ctl_if.rate     = {st.rate_hi, st.rate_lo};
    assign ctl_if.ld_sec   = {st.hold_sec_hi, st.hold_sec_lo};
    assign ctl_if.ld_ns    = {st.hold_ns_hi, st.hold_ns_lo};
    assign ctl_if.ld_phase = st.hold_phase;
    assign ctl_if.step_ns  = {st.hold_ns_hi, st.hold_ns_lo};

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    // one select per register word, shared by the action and read paths
    logic sel_ctrl;
    logic sel_phase;
    logic sel_ns_hi;
    logic sel_ns_lo;
    logic sel_sec_hi;
    logic sel_sec_lo;
    logic sel_rate_hi;
    logic sel_rate_lo;

    always_comb begin
        sel_ctrl    = 1'b0;
        sel_phase   = 1'b0;
        sel_ns_hi   = 1'b0;
        sel_ns_lo   = 1'b0;
        sel_sec_hi  = 1'b0;
        sel_sec_lo  = 1'b0;
        sel_rate_hi = 1'b0;
        sel_rate_lo = 1'b0;
        case (i_reg_addr)
            OFS_CLOCK_CONTROL: begin
                sel_ctrl = 1'b1;
            end
            OFS_PHASE: begin
                sel_phase = 1'b1;
            end
            OFS_NS_HIGH: begin
                sel_ns_hi = 1'b1;
            end
            OFS_NS_LOW: begin
                sel_ns_lo = 1'b1;
            end
            OFS_SEC_HIGH: begin
                sel_sec_hi = 1'b1;
            end
            OFS_SEC_LOW: begin
                sel_sec_lo = 1'b1;
            end
            OFS_RATE_HIGH: begin
                sel_rate_hi = 1'b1;
            end
            OFS_RATE_LOW: begin
                sel_rate_lo = 1'b1;
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // self-clearing action requests

    // an action bit written as one becomes a pulse of exactly one cycle
    logic ctl_wr;
    logic req_step;
    logic req_snap;
    logic req_load;
    logic req_clr;

    assign ctl_wr   = i_reg_wr & sel_ctrl;
    assign req_step = ctl_wr & i_reg_wdata[BIT_STEP];
    assign req_snap = ctl_wr & i_reg_wdata[BIT_SNAPSHOT];
    assign req_load = ctl_wr & i_reg_wdata[BIT_LOAD];
    assign req_clr  = ctl_wr & i_reg_wdata[BIT_CLK_RESET];

    ////////////////////////////////////////////////////////////////////////////////
    // read images of the control, rate high and phase words

    logic [15:0] ctrl_word;
    logic [15:0] rate_hi_word;
    logic [15:0] phase_word;

    always_comb begin
        ctrl_word                = 16'h0000;
        ctrl_word[BIT_FOLLOW_DIS] = st.follow_dis;
        ctrl_word[BIT_STEP]      = st.step_p;
        ctrl_word[BIT_STEP_DIR]  = st.step_dir;
        ctrl_word[BIT_SNAPSHOT]  = st.snap_p;
        ctrl_word[BIT_LOAD]      = st.load_p;
        ctrl_word[BIT_CONT_ADJ]  = st.cont_en;
        ctrl_word[BIT_RUN]       = st.run;
        ctrl_word[BIT_CLK_RESET] = st.clr_p;
        rate_hi_word                = 16'h0000;
        rate_hi_word[BIT_RATE_DIR]  = st.rate_dir;
        rate_hi_word[BIT_TEMP_MODE] = st.temp_mode;
        rate_hi_word[RATE_HI_MSB:0] = st.rate_hi;
        phase_word                  = {13'h0000, st.hold_phase};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read-back selection

    // the addressed word, zero for an unmapped address
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = RST_WORD;
        if (sel_ctrl) begin
            rd_mux = ctrl_word;
        end
        if (sel_phase) begin
            rd_mux = phase_word;
        end
        if (sel_ns_hi) begin
            rd_mux = st.hold_ns_hi;
        end
        if (sel_ns_lo) begin
            rd_mux = st.hold_ns_lo;
        end
        if (sel_sec_hi) begin
            rd_mux = st.hold_sec_hi;
        end
        if (sel_sec_lo) begin
            rd_mux = st.hold_sec_lo;
        end
        if (sel_rate_hi) begin
            rd_mux = rate_hi_word;
        end
        if (sel_rate_lo) begin
            rd_mux = st.rate_lo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state: writes, actions, snapshot and read

    always_comb begin
        next_st = st;
        // action strobes last one cycle
        next_st.step_p = req_step;
        next_st.snap_p = req_snap;
        next_st.load_p = req_load;
        next_st.clr_p  = req_clr;
        next_st.rvalid = 1'b0;

        if (st.snap_p) begin
            next_st.hold_phase  = ctl_if.live_phase;
            next_st.hold_ns_hi  = ctl_if.live_ns[31:16];
            next_st.hold_ns_lo  = ctl_if.live_ns[15:0];
            next_st.hold_sec_hi = ctl_if.live_sec[31:16];
            next_st.hold_sec_lo = ctl_if.live_sec[15:0];
        end

        if (i_reg_wr) begin
            case (i_reg_addr)
                OFS_CLOCK_CONTROL: begin
                    next_st.follow_dis = i_reg_wdata[BIT_FOLLOW_DIS];
                    next_st.step_dir   = i_reg_wdata[BIT_STEP_DIR];
                    next_st.cont_en    = i_reg_wdata[BIT_CONT_ADJ];
                    next_st.run        = i_reg_wdata[BIT_RUN];
                end
                OFS_PHASE: begin
                    if (i_reg_wdata[2:0] > PHASE_MAX) begin
                        next_st.hold_phase = RST_PHASE;
                    end else begin
                        next_st.hold_phase = i_reg_wdata[2:0];
                    end
                end
                OFS_NS_HIGH: begin
                    next_st.hold_ns_hi = i_reg_wdata;
                end
                OFS_NS_LOW: begin
                    next_st.hold_ns_lo = i_reg_wdata;
                end
                OFS_SEC_HIGH: begin
                    next_st.hold_sec_hi = i_reg_wdata;
                end
                OFS_SEC_LOW: begin
                    next_st.hold_sec_lo = i_reg_wdata;
                end
                OFS_RATE_HIGH: begin
                    next_st.rate_dir  = i_reg_wdata[BIT_RATE_DIR];
                    next_st.temp_mode = i_reg_wdata[BIT_TEMP_MODE];
                    next_st.rate_hi   = i_reg_wdata[RATE_HI_MSB:0];
                end
                OFS_RATE_LOW: begin
                    next_st.rate_lo = i_reg_wdata;
                end
                default: begin
                end
            endcase
        end

        if (i_reg_rd) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd_mux;
        end

        // switch timers see the rate trim only when following is allowed
        next_st.adj_en  = st.cont_en & st.run & ~st.follow_dis;
        next_st.adj_dir = st.rate_dir;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_reg_rdata    = st.rdata;
    assign o_reg_rvalid   = st.rvalid;
    assign o_freq_adj_en  = st.adj_en;
    assign o_freq_adj_dir = st.adj_dir;
    assign o_rtc_running  = st.run;

endmodule

/* rtl/ptp_clock_pkg.sv */
// constants and types shared by the ptp real-time clock control block
package ptp_clock_pkg;

    // register byte offsets
    localparam logic [15:0] OFS_CLOCK_CONTROL = 16'h0500;
    localparam logic [15:0] OFS_PHASE         = 16'h0502;
    localparam logic [15:0] OFS_NS_HIGH       = 16'h0504;
    localparam logic [15:0] OFS_NS_LOW        = 16'h0506;
    localparam logic [15:0] OFS_SEC_HIGH      = 16'h0508;
    localparam logic [15:0] OFS_SEC_LOW       = 16'h050a;
    localparam logic [15:0] OFS_RATE_HIGH     = 16'h050c;
    localparam logic [15:0] OFS_RATE_LOW      = 16'h050e;

    // clock control field positions
    localparam int BIT_FOLLOW_DIS = 15;
    localparam int BIT_STEP       = 6;
    localparam int BIT_STEP_DIR   = 5;
    localparam int BIT_SNAPSHOT   = 4;
    localparam int BIT_LOAD       = 3;
    localparam int BIT_CONT_ADJ   = 2;
    localparam int BIT_RUN        = 1;
    localparam int BIT_CLK_RESET  = 0;

    // rate high word field positions
    localparam int BIT_RATE_DIR   = 15;
    localparam int BIT_TEMP_MODE  = 14;
    localparam int RATE_HI_MSB    = 13;
    localparam int RATE_WIDTH     = 30;

    // phase field
    localparam int          PHASE_WIDTH = 3;
    localparam logic [2:0]  PHASE_MAX   = 3'h4;

    // reset values
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [2:0]  RST_PHASE = 3'h0;

    // time advance
    localparam logic [32:0] NS_PER_TICK = 33'h000000028;
    localparam logic [32:0] NS_PER_SEC  = 33'h03b9aca00;

endpackage

/* rtl/rtc_ctl_if.sv */
// control and live-time signals between the register file and the time counter
`timescale 1ns/1ps
interface rtc_ctl_if;
    import ptp_clock_pkg::*;

    logic                   tick;
    logic                   run;
    logic                   clr;
    logic                   load;
    logic                   step;
    logic                   step_dir;
    logic                   cont_en;
    logic                   rate_dir;
    logic [RATE_WIDTH-1:0]  rate;
    logic [31:0]            ld_sec;
    logic [31:0]            ld_ns;
    logic [2:0]             ld_phase;
    logic [31:0]            step_ns;
    logic [31:0]            live_sec;
    logic [31:0]            live_ns;
    logic [2:0]             live_phase;

    modport ctl (
        output tick, run, clr, load, step, step_dir, cont_en, rate_dir, rate,
        output ld_sec, ld_ns, ld_phase, step_ns,
        input  live_sec, live_ns, live_phase
    );
    modport cnt (
        input  tick, run, clr, load, step, step_dir, cont_en, rate_dir, rate,
        input  ld_sec, ld_ns, ld_phase, step_ns,
        output live_sec, live_ns, live_phase
    );
endinterface

/* rtl/rtc_time_counter.sv */
// running seconds / nanoseconds counter with a loaded, non-advancing phase, step, load and rate adjust
`timescale 1ns/1ps
module rtc_time_counter
    import ptp_clock_pkg::*;
(
    input  wire logic   i_sys_clk,
    input  wire logic   i_rstn,
    rtc_ctl_if.cnt      ctl
);

    typedef struct packed {
        logic [31:0] sec;
        logic [31:0] ns;
        logic [31:0] frac;
        logic [2:0]  phase;
    } time_s;

    time_s st;
    time_s next_st;

    logic [32:0] frac_sum;
    logic [32:0] delta;
    logic [32:0] ns_a;
    logic [31:0] sec_a;
    logic [32:0] ns_b;

    always_comb begin
        next_st  = st;
        frac_sum = {1'b0, st.frac};
        delta    = NS_PER_TICK;
        ns_a     = {1'b0, st.ns};
        sec_a    = st.sec;
        ns_b     = 33'h000000000;
        if (ctl.run && ctl.tick) begin
            if (ctl.cont_en) begin
                if (ctl.rate_dir) begin
                    frac_sum = {1'b0, st.frac} + {3'h0, ctl.rate};
                    delta    = NS_PER_TICK + {32'h0, frac_sum[32]};
                end else begin
                    frac_sum = {1'b0, st.frac} - {3'h0, ctl.rate};
                    delta    = NS_PER_TICK - {32'h0, frac_sum[32]};
                end
                next_st.frac = frac_sum[31:0];
            end
            ns_a = {1'b0, st.ns} + delta;
            if (ns_a >= NS_PER_SEC) begin
                ns_a  = ns_a - NS_PER_SEC;
                sec_a = st.sec + 32'h1;
            end
        end
        next_st.ns  = ns_a[31:0];
        next_st.sec = sec_a;
        if (ctl.step) begin
            if (ctl.step_dir) begin
                ns_b = ns_a + {1'b0, ctl.step_ns};
                if (ns_b >= NS_PER_SEC) begin
                    ns_b        = ns_b - NS_PER_SEC;
                    next_st.sec = sec_a + 32'h1;
                end
            end else if (ns_a < {1'b0, ctl.step_ns}) begin
                ns_b        = ns_a + NS_PER_SEC - {1'b0, ctl.step_ns};
                next_st.sec = sec_a - 32'h1;
            end else begin
                ns_b = ns_a - {1'b0, ctl.step_ns};
            end
            next_st.ns = ns_b[31:0];
        end
        if (ctl.load) begin
            next_st.sec   = ctl.ld_sec;
            next_st.ns    = ctl.ld_ns;
            next_st.frac  = 32'h0;
            next_st.phase = (ctl.ld_phase > PHASE_MAX) ? RST_PHASE : ctl.ld_phase;
        end
        if (ctl.clr) begin
            next_st = '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ctl.live_sec   = st.sec;
    assign ctl.live_ns    = st.ns;
    assign ctl.live_phase = st.phase;

endmodule

/* tb/ptp_clock_control_properties.sv */
// concurrent checks on the ports of the ptp clock control block
`timescale 1ns/1ps
module ptp_clock_control_properties
    import ptp_clock_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_rstn,
    input wire logic        i_rtc_tick,
    input wire logic [15:0] i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic        o_freq_adj_en,
    input wire logic        o_freq_adj_dir,
    input wire logic        o_rtc_running
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    logic ctl_wr;
    logic rate_wr;
    logic run_set;
    logic run_clr;
    logic unmapped;
    assign ctl_wr   = i_reg_wr && (i_reg_addr == OFS_CLOCK_CONTROL);
    assign rate_wr  = i_reg_wr && (i_reg_addr == OFS_RATE_HIGH);
    assign run_set  = ctl_wr && i_reg_wdata[BIT_RUN];
    assign run_clr  = ctl_wr && !i_reg_wdata[BIT_RUN];
    assign unmapped = (i_reg_addr < OFS_CLOCK_CONTROL) || (i_reg_addr > OFS_RATE_LOW)
                    || i_reg_addr[0];

    ////////////////////////////////////////////////////////////////////////////////
    chk_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read strobe got no valid one cycle later");
    chk_valid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("read valid without a read strobe");
    chk_unmapped_zero: assert property (i_reg_rd && unmapped |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read returned nonzero data");
    chk_phase_legal: assert property (i_reg_rd && i_reg_addr == OFS_PHASE |=>
        o_reg_rdata[15:3] == 13'h0000 && o_reg_rdata[2:0] <= PHASE_MAX)
        else $error("phase read outside codes zero to four");
    chk_run_rise: assert property ($rose(o_rtc_running) |-> $past(run_set) || $past(run_set, 2))
        else $error("clock started without a run write");
    chk_run_fall: assert property ($fell(o_rtc_running) |-> $past(run_clr) || $past(run_clr, 2))
        else $error("clock stopped without a run clear");
    chk_adj_en_cause: assert property ($changed(o_freq_adj_en) |-> $past(ctl_wr) || $past(ctl_wr, 2))
        else $error("follow enable changed without a control write");
    chk_dir_cause: assert property ($changed(o_freq_adj_dir) |-> $past(rate_wr) || $past(rate_wr, 2))
        else $error("rate direction changed without a rate write");
    chk_rdata_hold: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
        else $error("read data moved between reads");

    cover property (ctl_wr && i_reg_wdata[BIT_SNAPSHOT]);
    cover property ($rose(o_freq_adj_en));
    cover property (i_rtc_tick && o_rtc_running);
endmodule

bind ptp_clock_control ptp_clock_control_properties u_props (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_rtc_tick(i_rtc_tick), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_freq_adj_en(o_freq_adj_en),
    .o_freq_adj_dir(o_freq_adj_dir), .o_rtc_running(o_rtc_running)
);

/* tb/test_ptp_clock_control.sv */
// self-checking bench for the ptp clock control block
`timescale 1ns/1ps
module test_ptp_clock_control;
    import ptp_clock_pkg::*;

    logic        i_sys_clk, i_rstn, i_rtc_tick, i_reg_wr, i_reg_rd;
    logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic        o_reg_rvalid, o_freq_adj_en, o_freq_adj_dir, o_rtc_running;
    int          bad_count = 0;
    int          checked   = 0;
    int          cycles    = 0;
    logic [15:0] ctl, rd_word, rd_hi;
    // each row: address, write data, expected read back
    logic [47:0] rows [11] = '{
        {OFS_NS_HIGH, 16'h1234, 16'h1234}, {OFS_NS_LOW, 16'habcd, 16'habcd},
        {OFS_SEC_HIGH, 16'h5a5a, 16'h5a5a}, {OFS_SEC_LOW, 16'ha5a5, 16'ha5a5},
        {OFS_RATE_HIGH, 16'hffff, 16'hffff}, {OFS_RATE_LOW, 16'h0001, 16'h0001},
        {OFS_PHASE, 16'h0003, 16'h0003}, {OFS_PHASE, 16'h0006, 16'h0000},
        {OFS_PHASE, 16'hfffc, 16'h0004}, {OFS_CLOCK_CONTROL, 16'hff84, 16'h8004},
        {16'h0520, 16'hffff, 16'h0000}};

    ptp_clock_control u_dut (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_rtc_tick(i_rtc_tick),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .o_freq_adj_en(o_freq_adj_en), .o_freq_adj_dir(o_freq_adj_dir),
        .o_rtc_running(o_rtc_running));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [15:0] a);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        #1;
        check("rvalid", o_reg_rvalid, 1'b1);
        rd_word = o_reg_rdata;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_sys_clk);
            i_rtc_tick <= 1'b1;
            @(posedge i_sys_clk);
            i_rtc_tick <= 1'b0;
        end
        #1;
    endtask
    task automatic load_time(input logic [31:0] sec, input logic [31:0] ns, input logic [2:0] ph);
        reg_wr(OFS_PHASE, {13'h0000, ph});
        reg_wr(OFS_NS_HIGH, ns[31:16]);
        reg_wr(OFS_NS_LOW, ns[15:0]);
        reg_wr(OFS_SEC_HIGH, sec[31:16]);
        reg_wr(OFS_SEC_LOW, sec[15:0]);
        reg_wr(OFS_CLOCK_CONTROL, ctl | 16'h0008);
    endtask
    task automatic snap(input logic [31:0] sec, input logic [31:0] ns, input logic [2:0] ph);
        reg_wr(OFS_CLOCK_CONTROL, ctl | 16'h0010);
        reg_rd(OFS_CLOCK_CONTROL);
        check("control", rd_word, ctl);
        reg_rd(OFS_PHASE);
        check("phase", rd_word, {13'h0000, ph});
        reg_rd(OFS_NS_HIGH);
        rd_hi = rd_word;
        reg_rd(OFS_NS_LOW);
        check("nanoseconds", {rd_hi, rd_word}, ns);
        reg_rd(OFS_SEC_HIGH);
        rd_hi = rd_word;
        reg_rd(OFS_SEC_LOW);
        check("seconds", {rd_hi, rd_word}, sec);
    endtask
    task automatic step(input logic [31:0] ns, input logic add);
        reg_wr(OFS_NS_HIGH, ns[31:16]);
        reg_wr(OFS_NS_LOW, ns[15:0]);
        reg_wr(OFS_CLOCK_CONTROL, ctl | 16'h0040 | (add ? 16'h0020 : 16'h0000));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        i_rstn      = 1'b0;
        i_rtc_tick  = 1'b0;
        i_reg_wr    = 1'b0;
        i_reg_rd    = 1'b0;
        i_reg_addr  = 16'h0000;
        i_reg_wdata = 16'h0000;
        ctl         = 16'h0000;
        repeat (10) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            reg_rd(OFS_CLOCK_CONTROL + 16'(2 * i));
            check("reset value", rd_word, 16'h0000);
        end
        foreach (rows[i]) begin
            reg_wr(rows[i][47:32], rows[i][31:16]);
            reg_rd(rows[i][47:32]);
            check("register", rd_word, rows[i][15:0]);
        end
        check("adjust dir", o_freq_adj_dir, 1'b1);
        check("adjust en", o_freq_adj_en, 1'b0);
        ctl = 16'h0002;
        load_time(32'd5, 32'h3b9ac9d8, 3'h3);
        tick(1);
        snap(32'd6, 32'd0, 3'h3);
        check("running", o_rtc_running, 1'b1);
        tick(3);
        snap(32'd6, 32'd120, 3'h3);
        ctl = 16'h0000;
        reg_wr(OFS_CLOCK_CONTROL, ctl);
        tick(2);
        snap(32'd6, 32'd120, 3'h3);
        check("running", o_rtc_running, 1'b0);
        step(32'd1000, 1'b1);
        snap(32'd6, 32'd1120, 3'h3);
        step(32'd2000, 1'b0);
        snap(32'd5, 32'h3b9ac690, 3'h3);
        reg_wr(OFS_RATE_HIGH, 16'h3fff);
        reg_wr(OFS_RATE_LOW, 16'hffff);
        ctl = 16'h0006;
        load_time(32'd0, 32'd0, 3'h0);
        tick(1);
        check("adjust en", o_freq_adj_en, 1'b1);
        check("adjust dir", o_freq_adj_dir, 1'b0);
        reg_wr(OFS_RATE_HIGH, 16'hbfff);
        tick(1);
        snap(32'd0, 32'd80, 3'h0);
        ctl = 16'h8006;
        reg_wr(OFS_CLOCK_CONTROL, ctl);
        reg_rd(OFS_CLOCK_CONTROL);
        check("control", rd_word, ctl);
        check("adjust en", o_freq_adj_en, 1'b0);
        load_time(32'd9, 32'd400, 3'h2);
        reg_wr(OFS_CLOCK_CONTROL, ctl | 16'h0001);
        snap(32'd0, 32'd0, 3'h0);
        load_time(32'd9, 32'd400, 3'h2);
        @(posedge i_sys_clk);
        i_rstn <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        #1;
        check("running", o_rtc_running, 1'b0);
        check("adjust dir", o_freq_adj_dir, 1'b0);
        ctl = 16'h0000;
        snap(32'd0, 32'd0, 3'h0);
        print_verdict();
    end
endmodule
